/* scsc_pkg.sv */
// shared constants, tables and carriers for the stealing-mode speech codec
package scsc_pkg;

    localparam int FRAME_BITS = 137;
    localparam int T2_BITS = 145;
    localparam int T3_BITS = 216;
    localparam int SLOT_BITS = 432;

    localparam int C0_BITS = 51;
    localparam int C1_BITS = 56;
    localparam int C2_BITS = 30;
    localparam int PAR_BITS = 4;
    localparam int TAIL_BITS = 4;
    localparam int C1_START = C0_BITS;
    localparam int C2_START = C0_BITS + C1_BITS;
    localparam int PAR_START = C2_START + C2_BITS;
    localparam int CODED_BITS = C1_BITS + C2_BITS + PAR_BITS + TAIL_BITS;

    localparam logic [3:0] CRC_INIT = 4'h0;
    localparam logic [3:0] CRC_POLY = 4'h3;

    localparam int MOTHER_N = 3;
    localparam logic [4:0] GEN [0:MOTHER_N-1] = '{5'h13, 5'h1d, 5'h17};

    localparam int P23_PERIOD = 6;
    localparam logic [5:0] P23_MASK = 6'h0b;
    localparam int P817_PERIOD = 24;
    localparam logic [23:0] P817_MASK = 24'h6db6df;

    // interleaver step, coprime with the block size
    localparam int ILV_STEP = 101;

    // speech-frame bit number (1-based) at each type-2 position
    localparam logic [7:0] PERM [0:FRAME_BITS-1] = '{
        8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2f,
        8'h30, 8'h38, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
        8'h45, 8'h46, 8'h4a, 8'h4b, 8'h53, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c,
        8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h65, 8'h66, 8'h6e, 8'h73, 8'h74,
        8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h80, 8'h81,
        8'h89, 8'h3a, 8'h55, 8'h70, 8'h36, 8'h51, 8'h6c, 8'h87, 8'h32, 8'h4d,
        8'h68, 8'h83, 8'h2d, 8'h48, 8'h63, 8'h7e, 8'h37, 8'h52, 8'h6d, 8'h88,
        8'h05, 8'h0d, 8'h22, 8'h08, 8'h10, 8'h11, 8'h16, 8'h17, 8'h18, 8'h19,
        8'h1a, 8'h06, 8'h0e, 8'h07, 8'h0f, 8'h3c, 8'h57, 8'h72, 8'h2e, 8'h49,
        8'h64, 8'h7f, 8'h2c, 8'h47, 8'h62, 8'h7d, 8'h21, 8'h31, 8'h4c, 8'h67,
        8'h82, 8'h3b, 8'h56, 8'h71, 8'h39, 8'h54, 8'h6f, 8'h12, 8'h13, 8'h14,
        8'h15, 8'h1f, 8'h20, 8'h35, 8'h50, 8'h6b, 8'h86, 8'h01, 8'h02, 8'h03,
        8'h04, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h34,
        8'h4f, 8'h6a, 8'h85, 8'h33, 8'h4e, 8'h69, 8'h84
    };

    typedef struct packed {
        logic stolen;
        logic [SLOT_BITS-1:0] bits;
    } scsc_rx_in_s;

    typedef struct packed {
        logic stolen;
        logic bad_frame_indicator;
        logic [FRAME_BITS-1:0] frame;
    } scsc_rx_out_s;

endpackage : scsc_pkg

/* scsc_codec.sv */
// stealing-mode speech channel coder and decoder
`timescale 1ns/100ps

// Operation
// [R01] stolen slot: speech coded alone, output as one second-half block
// [R02] coder takes one 137-bit speech frame per block
// [R03] 4-bit crc with generator 1+X+X^4 over the 30 most sensitive bits
// [R04] type-2 block: 51 + 56 + 30 + 4 parity + 4 tail = 145 bits
// [R05] fixed frame-bit order from table, parity at positions 138 to 141
// [R06] only the two most sensitive classes are convolutionally coded
// [R07] medium class at rate 2/3, sensitive class plus parity and tail at 8/17
// [R08] coded block is 51 + 84 + 81 = 216 bits
// [R09] rate 2/3 stage reuses the normal-channel puncturing
// [R10] rate 2/3 keeps positions 1, 2, 4 of every 6
// [R11] rate 8/17 keeps 17 listed positions of every 24
// [R12] 216 coded bits interleaved as the stolen signalling channel
// [R13] receive block is deinterleaved first
// [R14] deinterleaved bits convolutionally decoded into classes and parity
// [R15] recomputed parity differs from received parity: bad frame flagged
// [R16] decoded classes delivered with the bad-frame flag per block
// [R17] one block at a time, strategy chosen by stealing flag with the block
// [R18] normal slot: 432-bit block holding two frames; here not decoded, one entry flagged bad with a zero frame
// [R19] stolen slot: 216-bit block holding one frame
// [R20] tail bits zero, crc register cleared at each frame
module scsc_codec (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic [scsc_pkg::FRAME_BITS-1:0] tx_in_frame,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic [scsc_pkg::T3_BITS-1:0] tx_out_bits,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire scsc_pkg::scsc_rx_in_s rx_in,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output scsc_pkg::scsc_rx_out_s rx_out
);

    localparam int BUF_DEPTH = 2;

    // crc over the sensitive class of a type-2 block
    function automatic logic [3:0] crc_calc(input logic [scsc_pkg::T2_BITS-1:0] t2);
        logic [3:0] c;
        logic fb;
        c = scsc_pkg::CRC_INIT; // [R20]
        for (int i = 0; i < scsc_pkg::C2_BITS; i++) begin
            fb = t2[scsc_pkg::C2_START + i] ^ c[3];
            c = {c[2:0], 1'b0} ^ (fb ? scsc_pkg::CRC_POLY : 4'h0); // [R03]
        end
        return c;
    endfunction : crc_calc

    // puncturing decision for a mother-code position within a class
    function automatic logic keep_pos(input logic sens, input int pos);
        if (sens) begin
            keep_pos = scsc_pkg::P817_MASK[pos % scsc_pkg::P817_PERIOD]; // [R11]
        end else begin
            keep_pos = scsc_pkg::P23_MASK[pos % scsc_pkg::P23_PERIOD]; // [R09] [R10]
        end
    endfunction : keep_pos

    // interleaver address
    function automatic int ilv_addr(input int i);
        return (scsc_pkg::ILV_STEP * i) % scsc_pkg::T3_BITS;
    endfunction : ilv_addr

    // transmit chain: frame to 216 interleaved bits
    function automatic logic [scsc_pkg::T3_BITS-1:0] encode(
        input logic [scsc_pkg::FRAME_BITS-1:0] frame
    );
        logic [scsc_pkg::T2_BITS-1:0] t2;
        logic [scsc_pkg::T3_BITS-1:0] t3;
        logic [scsc_pkg::T3_BITS-1:0] t4;
        logic [3:0] par;
        logic [3:0] sh;
        logic sens;
        int o;
        int pos;
        t2 = '0; // [R20]
        t3 = '0;
        t4 = '0;
        for (int p = 0; p < scsc_pkg::FRAME_BITS; p++) begin
            t2[p] = frame[int'(scsc_pkg::PERM[p]) - 1]; // [R02] [R05]
        end
        par = crc_calc(t2);
        for (int k = 0; k < scsc_pkg::PAR_BITS; k++) begin
            t2[scsc_pkg::PAR_START + k] = par[scsc_pkg::PAR_BITS - 1 - k]; // [R04] [R05]
        end
        for (int i = 0; i < scsc_pkg::C0_BITS; i++) begin
            t3[i] = t2[i]; // [R06]
        end
        o = scsc_pkg::C0_BITS;
        sh = '0;
        for (int i = 0; i < scsc_pkg::CODED_BITS; i++) begin
            sens = (i >= scsc_pkg::C1_BITS);
            for (int g = 0; g < scsc_pkg::MOTHER_N; g++) begin
                pos = (sens ? i - scsc_pkg::C1_BITS : i) * scsc_pkg::MOTHER_N + g;
                if (keep_pos(sens, pos)) begin
                    t3[o] = ^({sh, t2[scsc_pkg::C1_START + i]} & scsc_pkg::GEN[g]); // [R07]
                    o++;
                end
            end
            sh = {sh[2:0], t2[scsc_pkg::C1_START + i]};
        end
        // o has reached 216 here
        for (int i = 0; i < scsc_pkg::T3_BITS; i++) begin
            t4[ilv_addr(i)] = t3[i]; // [R08] [R12]
        end
        return t4;
    endfunction : encode

    // receive chain for a stolen half slot: bad flag and frame
    function automatic logic [scsc_pkg::FRAME_BITS:0] decode(
        input logic [scsc_pkg::T3_BITS-1:0] r
    );
        logic [scsc_pkg::T3_BITS-1:0] t3;
        logic [scsc_pkg::T2_BITS-1:0] t2;
        logic [scsc_pkg::FRAME_BITS-1:0] frame;
        logic [3:0] par;
        logic [3:0] rpar;
        logic [3:0] sh;
        logic c1;
        logic u;
        logic sens;
        int o;
        int pos;
        t3 = '0;
        t2 = '0;
        frame = '0;
        rpar = '0;
        c1 = 1'b0;
        for (int i = 0; i < scsc_pkg::T3_BITS; i++) begin
            t3[i] = r[ilv_addr(i)]; // [R13]
        end
        for (int i = 0; i < scsc_pkg::C0_BITS; i++) begin
            t2[i] = t3[i];
        end
        o = scsc_pkg::C0_BITS;
        sh = '0;
        for (int i = 0; i < scsc_pkg::CODED_BITS; i++) begin
            sens = (i >= scsc_pkg::C1_BITS);
            for (int g = 0; g < scsc_pkg::MOTHER_N; g++) begin
                pos = (sens ? i - scsc_pkg::C1_BITS : i) * scsc_pkg::MOTHER_N + g;
                if (keep_pos(sens, pos)) begin
                    if (g == 0) begin
                        c1 = t3[o];
                    end
                    o++;
                end
            end
            // first generator output is never punctured: invert it
            u = c1 ^ (^(sh & scsc_pkg::GEN[0][4:1])); // [R14]
            t2[scsc_pkg::C1_START + i] = u;
            sh = {sh[2:0], u};
        end
        for (int p = 0; p < scsc_pkg::FRAME_BITS; p++) begin
            frame[int'(scsc_pkg::PERM[p]) - 1] = t2[p]; // [R16]
        end
        for (int k = 0; k < scsc_pkg::PAR_BITS; k++) begin
            rpar[scsc_pkg::PAR_BITS - 1 - k] = t2[scsc_pkg::PAR_START + k];
        end
        par = crc_calc(t2);
        return {par != rpar, frame}; // [R15]
    endfunction : decode

    // transmit output stage
    logic tx_valid_ff;
    logic [scsc_pkg::T3_BITS-1:0] tx_bits_ff;
    logic tx_take;

    assign tx_in_ready = !tx_valid_ff || tx_out_ready;
    assign tx_take = tx_in_valid && tx_in_ready;
    assign tx_out_valid = tx_valid_ff;
    assign tx_out_bits = tx_bits_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_valid_ff <= 1'b0;
        end else if (tx_take) begin
            tx_valid_ff <= 1'b1;
        end else if (tx_out_ready) begin
            tx_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_bits_ff <= '0;
        end else if (tx_take) begin
            tx_bits_ff <= encode(tx_in_frame); // [R01]
        end
    end

    // receive decode and two-entry output buffer
    scsc_pkg::scsc_rx_out_s buf_ff [0:BUF_DEPTH-1];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] cnt_ff;
    logic rx_take;
    logic rx_give;
    logic [scsc_pkg::FRAME_BITS:0] dec;
    scsc_pkg::scsc_rx_out_s nxt_entry;

    assign rx_in_ready = (cnt_ff != 2'(BUF_DEPTH)); // [R17]
    assign rx_take = rx_in_valid && rx_in_ready;
    assign rx_out_valid = (cnt_ff != 2'h0);
    assign rx_give = rx_out_valid && rx_out_ready;
    assign rx_out = buf_ff[rd_ptr_ff];
    assign dec = decode(rx_in.bits[scsc_pkg::T3_BITS-1:0]); // [R19]

    always_comb begin
        nxt_entry.stolen = rx_in.stolen;
        if (rx_in.stolen) begin
            nxt_entry.bad_frame_indicator = dec[scsc_pkg::FRAME_BITS];
            nxt_entry.frame = dec[scsc_pkg::FRAME_BITS-1:0]; // [R17] [R19]
        end else begin
            // full slot consumed whole; not decoded, flagged bad with a zero frame
            nxt_entry.bad_frame_indicator = 1'b1; // [R18]
            nxt_entry.frame = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_ff[i] <= '0;
            end
        end else if (rx_take) begin
            buf_ff[wr_ptr_ff] <= nxt_entry; // [R16]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
        end else begin
            if (rx_take) begin
                wr_ptr_ff <= !wr_ptr_ff;
            end
            if (rx_give) begin
                rd_ptr_ff <= !rd_ptr_ff;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= 2'h0;
        end else if (rx_take && !rx_give) begin
            cnt_ff <= cnt_ff + 2'h1;
        end else if (rx_give && !rx_take) begin
            cnt_ff <= cnt_ff - 2'h1;
        end
    end

endmodule : scsc_codec

/* scsc_codec_properties.sv */
// port assertions for the codec
`timescale 1ns/100ps
module scsc_codec_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tx_in_valid,
    input wire logic tx_in_ready,
    input wire logic [scsc_pkg::FRAME_BITS-1:0] tx_in_frame,
    input wire logic tx_out_valid,
    input wire logic tx_out_ready,
    input wire logic [scsc_pkg::T3_BITS-1:0] tx_out_bits,
    input wire logic rx_in_valid,
    input wire logic rx_in_ready,
    input wire scsc_pkg::scsc_rx_in_s rx_in,
    input wire logic rx_out_valid,
    input wire logic rx_out_ready,
    input wire scsc_pkg::scsc_rx_out_s rx_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic tx_take = tx_in_valid && tx_in_ready;
    wire logic rx_take = rx_in_valid && rx_in_ready && !rx_out_valid;
    a_tx_answer_next: assert property (tx_take |=> tx_out_valid)
        else $error("tx block late");
    a_tx_zero_code: assert property (tx_take && tx_in_frame == '0 |=> tx_out_bits == '0)
        else $error("zero frame gave nonzero block");
    a_tx_hold_stall: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_bits))
        else $error("tx block lost in stall");
    a_tx_ready_rule: assert property (tx_in_ready == (!tx_out_valid || tx_out_ready))
        else $error("tx ready wrong");
    a_tx_drain_idle: assert property (tx_out_valid && tx_out_ready && !tx_in_valid |=> !tx_out_valid)
        else $error("tx block repeated");
    a_rx_answer_next: assert property (rx_take |=> rx_out_valid && rx_out.stolen == $past(rx_in.stolen))
        else $error("rx entry late or wrong mode");
    a_rx_hold_stall: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out))
        else $error("rx entry lost in stall");
    a_rx_normal_bad: assert property (rx_take && !rx_in.stolen |=> rx_out.bad_frame_indicator && rx_out.frame == '0)
        else $error("normal slot not flagged");
    c_tx_stall: cover property (tx_out_valid && !tx_out_ready && tx_in_valid);
    c_rx_full: cover property (rx_in_valid && !rx_in_ready);
    c_rx_bad: cover property (rx_out_valid && rx_out.stolen && rx_out.bad_frame_indicator);
endmodule : scsc_codec_properties

bind scsc_codec scsc_codec_properties u_props (.ref_clk(ref_clk), .rst(rst),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_frame(tx_in_frame),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_out_bits(tx_out_bits),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_in(rx_in),
    .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .rx_out(rx_out));

/* scsc_modem_model.sv */
// modulator model: takes coded blocks, may stall
`timescale 1ns/100ps
module scsc_modem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic tx_out_valid,
    output logic tx_out_ready,
    input wire logic [scsc_pkg::T3_BITS-1:0] tx_out_bits
);
    logic [scsc_pkg::T3_BITS-1:0] got_q[$];
    assign tx_out_ready = !stall;
    always @(posedge ref_clk) begin
        if (rst) begin
            got_q.delete();
        end else if (tx_out_valid && tx_out_ready) begin
            got_q.push_back(tx_out_bits);
        end
    end
endmodule : scsc_modem_model

/* tb_top.sv */
// testbench: codec against a reference coder
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic stall = 1'b0;
    logic tx_in_valid = 1'b0;
    logic rx_in_valid = 1'b0;
    logic rx_out_ready = 1'b0;
    logic [136:0] tx_in_frame = '0;
    scsc_pkg::scsc_rx_in_s rx_in = '0;
    logic tx_in_ready, tx_out_valid, tx_out_ready, rx_in_ready, rx_out_valid;
    logic [215:0] tx_out_bits;
    scsc_pkg::scsc_rx_out_s rx_out;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int seen = 0;
    always #2 ref_clk = ~ref_clk;
    scsc_codec dut (.ref_clk(ref_clk), .rst(rst), .tx_in_valid(tx_in_valid),
        .tx_in_ready(tx_in_ready), .tx_in_frame(tx_in_frame), .tx_out_valid(tx_out_valid),
        .tx_out_ready(tx_out_ready), .tx_out_bits(tx_out_bits), .rx_in_valid(rx_in_valid),
        .rx_in_ready(rx_in_ready), .rx_in(rx_in), .rx_out_valid(rx_out_valid),
        .rx_out_ready(rx_out_ready), .rx_out(rx_out));
    scsc_modem_model u_modem (.ref_clk(ref_clk), .rst(rst), .stall(stall),
        .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready), .tx_out_bits(tx_out_bits));
    function automatic logic [136:0] pat(input int k);
        logic [159:0] w;
        w = {5{32'h9e3779b9 * k}};
        return k[0] ? ~w[136:0] : w[136:0];
    endfunction : pat
    function automatic logic [215:0] ref_code(input logic [136:0] f, input logic [3:0] px);
        logic [144:0] t2;
        logic [215:0] t3;
        logic [215:0] t4;
        logic [3:0] c;
        logic [4:0] w;
        logic keep;
        int k;
        int p;
        t2 = '0;
        c = 4'h0;
        w = 5'h00;
        k = 51;
        for (int i = 0; i < 137; i++) t2[i] = f[scsc_pkg::PERM[i] - 1];
        for (int i = 107; i < 137; i++) c = {c[2:0], 1'b0} ^ ((t2[i] ^ c[3]) ? 4'h3 : 4'h0);
        for (int j = 0; j < 4; j++) t2[137 + j] = c[3 - j] ^ px[j];
        t3[50:0] = t2[50:0];
        for (int i = 51; i < 145; i++) begin
            w = {w[3:0], t2[i]};
            p = 3 * (i < 107 ? i - 51 : i - 107);
            for (int g = 0; g < 3; g++) begin
                keep = i < 107 ? scsc_pkg::P23_MASK[(p + g) % 6]
                    : scsc_pkg::P817_MASK[(p + g) % 24];
                if (keep) begin
                    t3[k] = ^(w & scsc_pkg::GEN[g]);
                    k++;
                end
            end
        end
        for (int i = 0; i < 216; i++) t4[(scsc_pkg::ILV_STEP * i) % 216] = t3[i];
        return t4;
    endfunction : ref_code
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [215:0] got, input logic [215:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic time_out(input int t, input int lim);
        if (t >= lim) begin
            fail_count++;
            $display("CHECK FAILED at %0t: handshake timeout", $time);
        end
    endtask : time_out
    task automatic wait_hs(input bit rx);
        int t;
        t = 0;
        @(negedge ref_clk);
        while ((rx ? rx_in_ready : tx_in_ready) !== 1'b1 && t < 50) begin
            @(negedge ref_clk);
            t++;
        end
        time_out(t, 50);
        @(posedge ref_clk);
    endtask : wait_hs
    task automatic send_tx(input logic [136:0] f);
        tx_in_frame <= f;
        tx_in_valid <= 1'b1;
        wait_hs(1'b0);
    endtask : send_tx
    task automatic send_rx(input logic s, input logic [431:0] b);
        rx_in <= {s, b};
        rx_in_valid <= 1'b1;
        wait_hs(1'b1);
    endtask : send_rx
    task automatic wait_tx(input logic [136:0] f);
        int t;
        t = 0;
        seen++;
        while (u_modem.got_q.size() < seen && t < 100) begin
            @(posedge ref_clk);
            t++;
        end
        time_out(t, 100);
        chk(u_modem.got_q[seen - 1], ref_code(f, 4'h0), "coded block");
    endtask : wait_tx
    task automatic get_rx(input logic [138:0] exp);
        int t;
        t = 0;
        rx_out_ready <= 1'b1;
        @(negedge ref_clk);
        while (rx_out_valid !== 1'b1 && t < 50) begin
            @(negedge ref_clk);
            t++;
        end
        time_out(t, 50);
        chk(216'(rx_out), 216'(exp), "decoded entry");
        @(posedge ref_clk);
        rx_out_ready <= 1'b0;
    endtask : get_rx
    task automatic t_tx_basic;
        for (int k = 0; k < 6; k++) begin
            send_tx(pat(k));
            tx_in_valid <= 1'b0;
            wait_tx(pat(k));
        end
        $display("tx_basic done");
    endtask : t_tx_basic
    task automatic t_tx_stall;
        stall <= 1'b1;
        send_tx(pat(7));
        tx_in_frame <= pat(8);
        @(negedge ref_clk);
        chk(216'(tx_in_ready), 216'h0, "tx not refused");
        repeat (4) @(posedge ref_clk);
        stall <= 1'b0;
        send_tx(pat(8));
        tx_in_valid <= 1'b0;
        wait_tx(pat(7));
        wait_tx(pat(8));
        $display("tx_stall done");
    endtask : t_tx_stall
    task automatic t_rx_decode;
        for (int k = 0; k < 8; k++) begin
            send_rx(1'b1, 432'(ref_code(pat(k), k < 4 ? 4'h0 : 4'h1 << (k - 4))));
            rx_in_valid <= 1'b0;
            get_rx({1'b1, k >= 4, pat(k)});
        end
        $display("rx_decode done");
    endtask : t_rx_decode
    task automatic t_rx_full;
        send_rx(1'b1, 432'(ref_code(pat(3), 4'h0)));
        send_rx(1'b0, {2{216'(pat(5))}});
        @(negedge ref_clk);
        chk(216'(rx_in_ready), 216'h0, "rx not refused");
        @(posedge ref_clk);
        rx_in_valid <= 1'b0;
        get_rx({1'b1, 1'b0, pat(3)});
        @(posedge ref_clk);
        get_rx({1'b0, 1'b1, 137'h0});
        $display("rx_full done");
    endtask : t_rx_full
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_tx_basic();
        t_tx_stall();
        t_rx_decode();
        t_rx_full();
        finish_test();
    end
endmodule : tb_top
